// >>> hw/etc_counter16.sv
// one 16-bit count-up counter with preload, low-byte buffer and pulse measurement
// assumes pin input already synchronised to pclk and tick strobes on pclk
`timescale 1ns/10ps
`include "etc_defs.svh"
module etc_counter16
	import etc_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter bit HAS_PIN = 1'b1
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// instruction clock strobe and synchronised pin
	input wire logic instr_tick,
	input wire logic pin_sync,
	// register access strobes
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic wr_ctrl,
	input wire logic rd_high,
	input wire logic [7:0] wdata,
	// observed state
	output logic [WIDTH-1:0] count,
	output logic [7:0] low_buf,
	output etc_ctrl_t ctrl,
	output logic ovf
);
	logic [WIDTH-1:0] preload; // only changed by a high-byte write
	logic pin_prev; // previous pin sample for edge detection
	etc_pw_t pw_state; // pulse measurement phase
	logic rise_edge;
	logic fall_edge;
	logic act_edge; // selected start transition
	logic back_edge; // return to original level
	logic inc; // count this cycle
	logic running;

	// edge detection by comparing consecutive samples
	assign rise_edge = pin_sync & ~pin_prev;
	assign fall_edge = ~pin_sync & pin_prev;
	assign act_edge = ctrl.edge_polarity_bit ? fall_edge : rise_edge;
	assign back_edge = ctrl.edge_polarity_bit ? rise_edge : fall_edge;
	assign running = ctrl.run_enable;
	// overflow strobe in the very cycle of the reload, so the flag lands with it
	assign ovf = inc && (&count);

	// increment condition per mode; suppressed while the high byte is read
	always_comb
	begin
		inc = 1'b0;
		if (running && !rd_high)
		begin
			unique case (ctrl.mode)
				ETC_MODE_EVENT: inc = HAS_PIN && act_edge;
				ETC_MODE_TIMER: inc = instr_tick;
				ETC_MODE_PULSE: inc = HAS_PIN && instr_tick && pw_state == ETC_PW_COUNT;
				ETC_MODE_UNUSED: inc = 1'b0;
			endcase
		end
	end

	// pin history
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_prev <= 1'b0;
		else
			pin_prev <= pin_sync;
	end

	// low-byte holding buffer: written by software, captured on high-byte read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_buf <= 8'h00;
		else if (rd_high)
			low_buf <= count[7:0];
		else if (wr_low)
			low_buf <= wdata;
	end

	// preload register, loaded as one word from high write plus buffer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			preload <= '0;
		else if (wr_high)
			preload <= WIDTH'({wdata, low_buf});
	end

	// the counter itself
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= '0;
		end
		else
		begin
			if (wr_high && !running)
				count <= WIDTH'({wdata, low_buf});
			else if (inc)
			begin
				if (&count)
				begin
					count <= preload;
				end
				else
					count <= count + 1'b1;
			end
		end
	end

	// control register and pulse measurement sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= etc_ctrl_t'(`ETC_CTRL_RESET);
			pw_state <= ETC_PW_ARMED;
		end
		else if (wr_ctrl)
		begin
			ctrl.mode <= etc_mode_t'(wdata[`ETC_BIT_MODE_HI:`ETC_BIT_MODE_LO]);
			ctrl.run_enable <= wdata[`ETC_BIT_RUN];
			ctrl.edge_polarity_bit <= wdata[`ETC_BIT_EDGE];
			pw_state <= ETC_PW_ARMED;
		end
		else if (running && ctrl.mode == ETC_MODE_PULSE && HAS_PIN)
		begin
			unique case (pw_state)
				ETC_PW_ARMED:
					if (act_edge)
						pw_state <= ETC_PW_COUNT;
				ETC_PW_COUNT:
					if (back_edge)
					begin
						pw_state <= ETC_PW_DONE;
						ctrl.run_enable <= 1'b0;
					end
				ETC_PW_DONE:
					pw_state <= ETC_PW_DONE;
				// the fourth code is never entered; fall back to armed
				default:
					pw_state <= ETC_PW_ARMED;
			endcase
		end
	end
endmodule : etc_counter16

// >>> hw/etc_defs.svh
// register offsets, field positions, reset values and timing constants of the timer block
// assumes inclusion by bare name from the design modules and the bench
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH
// register indices as printed; byte address is four times the index
`define ETC_IDX_A_HIGH 8'h0C
`define ETC_IDX_A_LOW 8'h0D
`define ETC_IDX_A_CTRL 8'h0E
`define ETC_IDX_B_HIGH 8'h0F
`define ETC_IDX_B_LOW 8'h10
`define ETC_IDX_B_CTRL 8'h11
`define ETC_IDX_C_HIGH 8'h20
`define ETC_IDX_C_LOW 8'h21
`define ETC_IDX_C_CTRL 8'h22
`define ETC_IDX_IRQ_LOW 8'h0B
`define ETC_IDX_IRQ_HIGH 8'h1E
`define ETC_IDX_D_LOW 8'h24
`define ETC_IDX_D_CTRL 8'h25
// control register fields
`define ETC_BIT_EDGE 3
`define ETC_BIT_RUN 4
`define ETC_BIT_MODE_LO 6
`define ETC_BIT_MODE_HI 7
`define ETC_CTRL_RMASK 8'hD8
`define ETC_TB_RMASK 8'hDF
// interrupt control fields
`define ETC_BIT_IE_A 2
`define ETC_BIT_IE_B 3
`define ETC_BIT_FLAG_A 5
`define ETC_BIT_FLAG_B 6
`define ETC_BIT_IE_C 0
`define ETC_BIT_IE_D 1
`define ETC_BIT_FLAG_C 4
`define ETC_BIT_FLAG_D 5
`define ETC_IRQL_RMASK 8'h6C
`define ETC_IRQH_RMASK 8'h33
// reset values
`define ETC_CTRL_RESET 8'h00
// instruction clock is the system clock divided by four
`define ETC_INSTR_DIV 4
`endif

// >>> hw/etc_pkg.sv
// types shared by the timer block
// assumes the defines header is available by bare name
package etc_pkg;
	// counter operating mode, mode_high_bit then mode_low_bit
	typedef enum logic [1:0] {
		ETC_MODE_UNUSED = 2'h0,
		ETC_MODE_EVENT = 2'h1,
		ETC_MODE_TIMER = 2'h2,
		ETC_MODE_PULSE = 2'h3
	} etc_mode_t;
	// decoded control fields of one 16-bit counter
	typedef struct packed {
		etc_mode_t mode;
		logic run_enable;
		logic edge_polarity_bit;
	} etc_ctrl_t;
	// pulse measurement phases
	typedef enum logic [1:0] {
		ETC_PW_ARMED,
		ETC_PW_COUNT,
		ETC_PW_DONE
	} etc_pw_t;
endpackage : etc_pkg

// >>> hw/etc_timers.sv
// Notes on behaviour
// - counters a/b count pin edges or instruction clock
// - low-byte write only fills holding buffer
// - high-byte write loads preload with buffer
// - high-byte read latches low count; read high first
// - counting suppressed during high-byte read
// - control bit 3 picks rising or falling edge
// - control bit 4 runs or stops counting
// - bits 7:6 select event, timer, pulse mode
// - count up from present value to FFFF
// - overflow reloads preload and sets request flag
// - pulse mode counts between edges, clears run
// - one pulse result held until re-enabled
// - pulse-mode overflow reloads and requests too
// - run bit not self-cleared in event/timer
// - overflow is a wake-up source
// - cleared interrupt enable blocks service
// - stopped counter loads on preload write
// - counter c uses instruction clock timer only
// - time base 8-bit, instruction or crystal clock
// - prescaler divides 2 to 256 by code
// - unused control bits read zero; time base bit 3 reads back as written
// - reset stops counters, clears prescaler
// - time base run bit4, mode bits 7:6
// - time base overflow sets its high flag
//
// timer/event block of four count-up counters behind an APB slave
// assumes event pins and the crystal clock are asynchronous to pclk
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "etc_defs.svh"
module etc_timers
	import etc_pkg::*;
#(
	parameter bit USE_CRYSTAL = 1'b0, // build-time clock choice of the time base
	parameter int INSTR_DIV = `ETC_INSTR_DIV
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external event pins and crystal level
	input wire logic event_input_a,
	input wire logic event_input_b,
	input wire logic crystal_in_pin,
	// halt wake-up and interrupt request towards the core
	output logic wake_up,
	output logic irq_request
);
	// instruction clock strobe from the system clock divided by four
	logic [$clog2(INSTR_DIV)-1:0] div_cnt;
	logic instr_clock;
	// two-stage synchronisers; stage one feeds only stage two
	logic [2:0] sync1;
	logic [2:0] sync2;
	// previous synchronised crystal level, used only to find its edges
	logic xtal_prev;
	// apb decode
	logic [9:0] idx;
	logic acc;
	logic wr;
	logic rd;
	logic hit;
	logic [7:0] rbyte;
	logic [7:0] wbyte;
	// per-counter strobes and state, index 0..2 = a, b, c
	logic [2:0] wr_low;
	logic [2:0] wr_high;
	logic [2:0] wr_ctrl;
	logic [2:0] rd_high;
	logic [2:0] ovf;
	logic [15:0] cnt [3];
	logic [7:0] lbuf [3];
	etc_ctrl_t ctl [3];
	// interrupt control registers
	logic [7:0] irq_low;
	logic [7:0] irq_high;
	// time base
	logic [7:0] tb_ctrl;
	logic [7:0] tb_count;
	logic [7:0] tb_preload;
	logic [7:0] prescale; // cleared by reset
	logic tb_src_tick;
	logic tb_tick;
	logic tb_ovf;
	logic [7:0] next_prescale;

	// apb decode: writes act only at the access edge; a read is seen from setup on,
	// so a high-byte read freezes its counter before prdata samples the high byte
	// and the low byte latched at the access edge belongs to that same count
	assign idx = paddr[11:2];
	assign acc = psel && penable;
	assign wr = acc && pwrite && pstrb[0];
	assign rd = psel && !pwrite;
	assign wbyte = pwdata[7:0];

	// instruction clock divider
	// runs free from reset; the strobe is one pclk wide, one edge in four
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end
	assign instr_clock = &div_cnt;

	// pin synchronisers
	// pins are sampled twice before any logic looks at them, against metastability;
	// this costs two to three pclk of latency on every pin edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			xtal_prev <= 1'b0;
		end
		else
		begin
			sync1 <= {crystal_in_pin, event_input_b, event_input_a};
			sync2 <= sync1;
			xtal_prev <= sync2[2];
		end
	end

	// strobe decode for the three 16-bit counters
	// one strobe per register; an unmapped index raises none of them
	always_comb
	begin
		wr_low = 3'h0;
		wr_high = 3'h0;
		wr_ctrl = 3'h0;
		rd_high = 3'h0;
		wr_low[0] = wr && idx == 10'(`ETC_IDX_A_LOW);
		wr_low[1] = wr && idx == 10'(`ETC_IDX_B_LOW);
		wr_low[2] = wr && idx == 10'(`ETC_IDX_C_LOW);
		wr_high[0] = wr && idx == 10'(`ETC_IDX_A_HIGH);
		wr_high[1] = wr && idx == 10'(`ETC_IDX_B_HIGH);
		wr_high[2] = wr && idx == 10'(`ETC_IDX_C_HIGH);
		wr_ctrl[0] = wr && idx == 10'(`ETC_IDX_A_CTRL);
		wr_ctrl[1] = wr && idx == 10'(`ETC_IDX_B_CTRL);
		wr_ctrl[2] = wr && idx == 10'(`ETC_IDX_C_CTRL);
		rd_high[0] = rd && idx == 10'(`ETC_IDX_A_HIGH);
		rd_high[1] = rd && idx == 10'(`ETC_IDX_B_HIGH);
		rd_high[2] = rd && idx == 10'(`ETC_IDX_C_HIGH);
	end

	// counters a and b have pins; c is instruction-clock only
	// counter c has no pin, so its event and pulse modes never count
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_cnt
			etc_counter16 #(
				.WIDTH(16),
				.HAS_PIN(gi < 2)
			) u_cnt (
				.pclk(pclk),
				.presetn(presetn),
				.instr_tick(instr_clock),
				.pin_sync(gi < 2 ? sync2[gi] : 1'b0),
				.wr_low(wr_low[gi]),
				.wr_high(wr_high[gi]),
				.wr_ctrl(wr_ctrl[gi]),
				.rd_high(rd_high[gi]),
				.wdata(wbyte),
				.count(cnt[gi]),
				.low_buf(lbuf[gi]),
				.ctrl(ctl[gi]),
				.ovf(ovf[gi])
			);
		end
	endgenerate

	// time base source: crystal edge or instruction clock, fixed at build
	assign tb_src_tick = USE_CRYSTAL ? (sync2[2] & ~xtal_prev) : instr_clock;

	// prescaler: divide by two to the power of code plus one
	// free running, so the first count after a code change may come early
	always_comb
	begin
		next_prescale = prescale;
		tb_tick = 1'b0;
		if (tb_src_tick)
		begin
			next_prescale = prescale + 8'h01;
			tb_tick = next_prescale[tb_ctrl[2:0]] & ~prescale[tb_ctrl[2:0]];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescale <= 8'h00;
		else
			prescale <= next_prescale;
	end

	// time base control, preload and counter
	// a preload write while stopped loads the count too, as on the big counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tb_ctrl <= `ETC_CTRL_RESET;
			tb_preload <= 8'h00;
			tb_count <= 8'h00;
			tb_ovf <= 1'b0;
		end
		else
		begin
			tb_ovf <= 1'b0;
			if (wr && idx == 10'(`ETC_IDX_D_CTRL))
				tb_ctrl <= wbyte & `ETC_TB_RMASK;
			if (wr && idx == 10'(`ETC_IDX_D_LOW))
			begin
				tb_preload <= wbyte;
				if (!tb_ctrl[`ETC_BIT_RUN])
					tb_count <= wbyte;
			end
			else if (tb_ctrl[`ETC_BIT_RUN] && tb_tick
				&& tb_ctrl[`ETC_BIT_MODE_HI:`ETC_BIT_MODE_LO] == 2'(ETC_MODE_TIMER))
			begin
				if (&tb_count)
				begin
					tb_count <= tb_preload;
					tb_ovf <= 1'b1;
				end
				else
					tb_count <= tb_count + 8'h01;
			end
		end
	end

	// interrupt control: hardware set wins over software clear
	// flags of a, b and c land in the reload cycle; a software clear in that
	// same cycle loses, so no overflow is ever dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_low <= 8'h00;
			irq_high <= 8'h00;
		end
		else
		begin
			if (wr && idx == 10'(`ETC_IDX_IRQ_LOW))
				irq_low <= wbyte & `ETC_IRQL_RMASK;
			if (wr && idx == 10'(`ETC_IDX_IRQ_HIGH))
				irq_high <= wbyte & `ETC_IRQH_RMASK;
			if (ovf[0])
				irq_low[`ETC_BIT_FLAG_A] <= 1'b1;
			if (ovf[1])
				irq_low[`ETC_BIT_FLAG_B] <= 1'b1;
			if (ovf[2])
				irq_high[`ETC_BIT_FLAG_C] <= 1'b1;
			if (tb_ovf)
				irq_high[`ETC_BIT_FLAG_D] <= 1'b1;
		end
	end

	// request gated by enables; wake-up pulses on any overflow
	// wake-up ignores the enables: any overflow may end a halt
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_request <= 1'b0;
			wake_up <= 1'b0;
		end
		else
		begin
			irq_request <= (irq_low[`ETC_BIT_FLAG_A] & irq_low[`ETC_BIT_IE_A])
				| (irq_low[`ETC_BIT_FLAG_B] & irq_low[`ETC_BIT_IE_B])
				| (irq_high[`ETC_BIT_FLAG_C] & irq_high[`ETC_BIT_IE_C])
				| (irq_high[`ETC_BIT_FLAG_D] & irq_high[`ETC_BIT_IE_D]);
			wake_up <= (|ovf) | tb_ovf;
		end
	end

	// control byte as software sees it; each field back at its own bit position
	// the stored struct is packed narrow, so a plain cast would misplace the fields
	function automatic logic [7:0] ctrl_byte(input etc_ctrl_t c);
		logic [7:0] b;
		b = 8'h00;
		b[`ETC_BIT_MODE_HI] = c.mode[1];
		b[`ETC_BIT_MODE_LO] = c.mode[0];
		b[`ETC_BIT_RUN] = c.run_enable;
		b[`ETC_BIT_EDGE] = c.edge_polarity_bit;
		return b & `ETC_CTRL_RMASK;
	endfunction : ctrl_byte

	// read mux; counter control reads mask unused bits to zero; time base control is only masked on write
	always_comb
	begin
		hit = 1'b1;
		rbyte = 8'h00;
		unique case (idx)
			10'(`ETC_IDX_A_HIGH): rbyte = cnt[0][15:8];
			10'(`ETC_IDX_A_LOW): rbyte = lbuf[0];
			10'(`ETC_IDX_A_CTRL): rbyte = ctrl_byte(ctl[0]);
			10'(`ETC_IDX_B_HIGH): rbyte = cnt[1][15:8];
			10'(`ETC_IDX_B_LOW): rbyte = lbuf[1];
			10'(`ETC_IDX_B_CTRL): rbyte = ctrl_byte(ctl[1]);
			10'(`ETC_IDX_C_HIGH): rbyte = cnt[2][15:8];
			10'(`ETC_IDX_C_LOW): rbyte = lbuf[2];
			10'(`ETC_IDX_C_CTRL): rbyte = ctrl_byte(ctl[2]);
			10'(`ETC_IDX_IRQ_LOW): rbyte = irq_low;
			10'(`ETC_IDX_IRQ_HIGH): rbyte = irq_high;
			10'(`ETC_IDX_D_LOW): rbyte = tb_count;
			10'(`ETC_IDX_D_CTRL): rbyte = tb_ctrl;
			default: hit = 1'b0;
		endcase
	end

	// apb answer: one access cycle, registered outputs
	// pready follows every setup by one cycle, so no master ever waits longer;
	// read data is taken at the setup edge and stands only in the access cycle,
	// which is why a high-byte read must already hold its counter during setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata <= (psel && !penable && !pwrite) ? {24'h000000, rbyte} : 32'h0000_0000;
		end
	end
endmodule : etc_timers

// >>> tb/etc_pins.sv
// event pin source for the two external counter inputs
// assumes the bench calls its tasks; lines hold each level long enough to be sampled
`timescale 1ns/10ps
module etc_pins (
	// clock
	input wire logic pclk,
	// event pins
	output logic event_input_a,
	output logic event_input_b
);
	// lines rest low until driven
	initial
	begin
		event_input_a = 1'b0;
		event_input_b = 1'b0;
	end
	// one line to a level, held for cyc clocks
	task automatic drive(input bit sel, input logic lvl, input int cyc);
		@(posedge pclk);
		if (sel)
			event_input_b <= lvl;
		else
			event_input_a <= lvl;
		repeat (cyc - 1) @(posedge pclk);
	endtask : drive
	// whole pulses, six clocks high and six low so sampling never misses one
	task automatic burst(input bit sel, input int cnt);
		repeat (cnt)
		begin
			drive(sel, 1'b1, 6);
			drive(sel, 1'b0, 6);
		end
	endtask : burst
endmodule : etc_pins

// >>> tb/etc_props.sv
// checker for the apb answer and wake-up output of the timer block
// assumes it is bound to etc_timers and sees its ports only
`timescale 1ns/10ps
module etc_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// requests
	input wire logic wake_up,
	input wire logic irq_request
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// setup phase of a transfer
	sequence s_setup;
		psel && !penable;
	endsequence
	// access phase carrying the answer
	sequence s_answer;
		psel && penable && pready;
	endsequence
	a_ready_next: assert property (s_setup |=> s_answer)
		else $error("no answer after setup");
	a_ready_cause: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	a_ready_once: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_err_cause: assert property (pslverr |-> pready)
		else $error("error without answer");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("error read not zero");
	a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_wake_pulse: assert property ($rose(wake_up) |=> !wake_up)
		else $error("wake pulse too long");
	a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
		else $error("answer while idle");
endmodule : etc_props

bind etc_timers etc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .wake_up(wake_up), .irq_request(irq_request));

// >>> tb/etc_timers_bench.sv
// self-checking bench for the timer block over apb
// assumes the defines header and the pin source model are compiled alongside
`timescale 1ns/10ps
`include "etc_defs.svh"
module etc_timers_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, wake_up, irq_request;
	logic event_input_a, event_input_b;
	int failures = 0;
	int num_checks = 0;
	int wakes = 0;
	int n, k;
	logic [31:0] rv; // last read data
	logic re; // last error answer
	logic [7:0] v; // held pulse result
	// 50 MHz clock
	always #10 pclk = ~pclk;
	etc_timers uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .event_input_a(event_input_a),
		.event_input_b(event_input_b), .crystal_in_pin(1'b0), .wake_up(wake_up),
		.irq_request(irq_request));
	etc_pins pins (.pclk(pclk), .event_input_a(event_input_a), .event_input_b(event_input_b));
	// count wake pulses
	always @(posedge pclk)
		if (wake_up === 1'b1)
			wakes++;
	// exact compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// compare within a tolerance; an unknown never passes
	task automatic near(input logic [31:0] got, input int exp, input int tol);
		num_checks++;
		if ((got >= exp - tol && got <= exp + tol) !== 1'b1)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : near
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends this wait
		while (pready !== 1'b1)
			@(posedge pclk);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rv, {24'h0, exp});
	endtask : rd
	// bounded wait for the request line
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq_request !== 1'b1 && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		if (n == lim)
			failures++;
	endtask : wait_irq
	task automatic conclude;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// watchdog well beyond the expected run
	initial
	begin
		#400000;
		failures++;
		conclude();
	end
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ETC_IDX_A_CTRL, 8'h00);
		rd(`ETC_IDX_C_CTRL, 8'h00);
		rd(`ETC_IDX_D_CTRL, 8'h00);
		apb(1'b0, 8'h3F, 8'h00);
		chk({31'h0, re}, 32'h1);
		wr(`ETC_IDX_A_CTRL, 8'hFF);
		rd(`ETC_IDX_A_CTRL, 8'hD8);
		wr(`ETC_IDX_D_CTRL, 8'hFF);
		rd(`ETC_IDX_D_CTRL, 8'hDF);
		wr(`ETC_IDX_D_CTRL, 8'h00);
		// stopped counter: high write loads, later low write only buffers
		wr(`ETC_IDX_A_CTRL, 8'h00);
		wr(`ETC_IDX_A_LOW, 8'h34);
		wr(`ETC_IDX_A_HIGH, 8'h12);
		wr(`ETC_IDX_A_LOW, 8'h56);
		rd(`ETC_IDX_A_HIGH, 8'h12);
		rd(`ETC_IDX_A_LOW, 8'h34);
		// event counting, rising then falling edge, then stopped
		wr(`ETC_IDX_A_LOW, 8'h00);
		wr(`ETC_IDX_A_HIGH, 8'h00);
		wr(`ETC_IDX_A_CTRL, 8'h50);
		pins.burst(1'b0, 5);
		repeat (8) @(posedge pclk);
		rd(`ETC_IDX_A_HIGH, 8'h00);
		rd(`ETC_IDX_A_LOW, 8'h05);
		wr(`ETC_IDX_A_CTRL, 8'h58);
		pins.drive(1'b0, 1'b1, 10);
		rd(`ETC_IDX_A_HIGH, 8'h00);
		rd(`ETC_IDX_A_LOW, 8'h05);
		pins.drive(1'b0, 1'b0, 10);
		rd(`ETC_IDX_A_HIGH, 8'h00);
		rd(`ETC_IDX_A_LOW, 8'h06);
		wr(`ETC_IDX_A_CTRL, 8'h48);
		pins.burst(1'b0, 2);
		rd(`ETC_IDX_A_HIGH, 8'h00);
		rd(`ETC_IDX_A_LOW, 8'h06);
		// one pulse of 40 clocks is ten instruction ticks, counted from zero
		wr(`ETC_IDX_A_CTRL, 8'h00);
		wr(`ETC_IDX_A_LOW, 8'h00);
		wr(`ETC_IDX_A_HIGH, 8'h00);
		wr(`ETC_IDX_A_CTRL, 8'hD0);
		pins.drive(1'b0, 1'b1, 40);
		pins.drive(1'b0, 1'b0, 10);
		rd(`ETC_IDX_A_HIGH, 8'h00);
		apb(1'b0, `ETC_IDX_A_LOW, 8'h00);
		near(rv, 10, 1);
		v = rv[7:0];
		rd(`ETC_IDX_A_CTRL, 8'hC0);
		pins.burst(1'b0, 2);
		rd(`ETC_IDX_A_HIGH, 8'h00);
		rd(`ETC_IDX_A_LOW, v);
		// timer overflow with the preload changed while running
		wr(`ETC_IDX_B_LOW, 8'hF0);
		wr(`ETC_IDX_B_HIGH, 8'hFF);
		wr(`ETC_IDX_IRQ_LOW, 8'h08);
		wr(`ETC_IDX_B_CTRL, 8'h90);
		wr(`ETC_IDX_B_LOW, 8'h00);
		wr(`ETC_IDX_B_HIGH, 8'h80);
		wait_irq(300);
		rd(`ETC_IDX_IRQ_LOW, 8'h48);
		rd(`ETC_IDX_B_HIGH, 8'h80);
		rd(`ETC_IDX_B_CTRL, 8'h90);
		// flag kept, enable cleared: the request must fall
		wr(`ETC_IDX_IRQ_LOW, 8'h40);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq_request}, 32'h0);
		rd(`ETC_IDX_IRQ_LOW, 8'h40);
		wr(`ETC_IDX_B_CTRL, 8'h00);
		// pulse-mode overflow: 15 ticks from FFF8 wrap once and raise flag a
		wr(`ETC_IDX_A_CTRL, 8'h00);
		wr(`ETC_IDX_A_LOW, 8'hF8);
		wr(`ETC_IDX_A_HIGH, 8'hFF);
		wr(`ETC_IDX_IRQ_LOW, 8'h04);
		wr(`ETC_IDX_A_CTRL, 8'hD0);
		pins.drive(1'b0, 1'b1, 60);
		pins.drive(1'b0, 1'b0, 10);
		rd(`ETC_IDX_IRQ_LOW, 8'h24);
		chk({31'h0, irq_request}, 32'h1);
		wr(`ETC_IDX_IRQ_LOW, 8'h00);
		// third counter ignores pin mode, counts in timer mode
		wr(`ETC_IDX_C_LOW, 8'hF8);
		wr(`ETC_IDX_C_HIGH, 8'hFF);
		wr(`ETC_IDX_IRQ_HIGH, 8'h01);
		wr(`ETC_IDX_C_CTRL, 8'h50);
		repeat (60) @(posedge pclk);
		rd(`ETC_IDX_C_HIGH, 8'hFF);
		rd(`ETC_IDX_C_LOW, 8'hF8);
		wr(`ETC_IDX_C_CTRL, 8'h90);
		wait_irq(300);
		rd(`ETC_IDX_IRQ_HIGH, 8'h11);
		wr(`ETC_IDX_C_CTRL, 8'h00);
		// time base: two counts per overflow at every prescale code
		for (k = 0; k < 8; k++)
		begin
			wr(`ETC_IDX_D_CTRL, 8'h00);
			wr(`ETC_IDX_IRQ_HIGH, 8'h02);
			wr(`ETC_IDX_D_LOW, 8'hFE);
			wr(`ETC_IDX_D_CTRL, 8'h90 | k[7:0]);
			wait_irq(5000);
			near(n, 2 ** (k + 4), 2 ** (k + 3) + 8);
			rd(`ETC_IDX_IRQ_HIGH, 8'h22);
		end
		wr(`ETC_IDX_D_CTRL, 8'h00);
		chk({31'h0, wakes > 0}, 32'h1);
		conclude();
	end
endmodule : etc_timers_bench
